// [logic/io_port_ctrl.sv]
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
// How it works
// - A pin with bidirectional enable set drives in its mode while its routed enable is high, else input.
// - Sixteen control-bus enables; any one may route to any number of pins.
// - Slew select reaches the pad in every mode except the three resistive pull modes.
// - Eight pins feed one interrupt unit with its own request line.
// - Each pin picks rising, falling, both edges, or no interrupt.
// - A matching edge sets the pin status bit and raises the request if the pin's mask bit is set.
// - Status register holds one bit per pin to identify the source.
// - Edge detection runs on the always-on clock, no sleep gating.
// - Only edge detection exists; no level-sensitive mode is offered.
// - Port-wide select picks CMOS (default) or LVTTL input thresholds.
// - Each pin has an input disable independent of drive mode.
// - Per-pin select chooses supply-level or regulated high output.
// - Resistive pull modes are refused while regulated output is on.
// - One port-wide reference select: half/0.4 supply, half/full reference.
// - Analog line may serve as comparator threshold, with hysteresis.
// - Reset leaves every pin analog high-impedance, driver and input off.
// - Port-form and per-pin registers are two views of the same bits.
module io_port_ctrl #(
   parameter int unsigned PINS = io_port_pkg::PIN_COUNT,
   parameter int unsigned OES  = io_port_pkg::OE_COUNT
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_b_in,
   // Register port
   input  wire logic [5:0]        addr_in,
   input  wire logic [7:0]        wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [7:0]        rdata_out,
   // Programmable logic side
   input  wire logic [OES-1:0]    aux_oe_in,
   input  wire logic [PINS-1:0]   sys_out_in,
   input  wire logic [PINS-1:0]   bypass_in,
   output logic      [PINS-1:0]   sys_in_out,
   // Pads
   input  wire logic [PINS-1:0]   pad_in,
   output logic      [PINS-1:0]   pad_out,
   output logic      [PINS-1:0]   pad_oe_out,
   output logic      [3*PINS-1:0] pad_mode_out,
   output logic      [PINS-1:0]   pad_slow_out,
   output logic      [PINS-1:0]   pad_in_en_out,
   output logic      [PINS-1:0]   pad_reg_out,
   // Port-wide analog controls
   output logic                   lvttl_out,
   output logic                   hyst_en_out,
   output logic      [1:0]        ref_sel_out,
   output logic                   comp_en_out,
   // Interrupt
   output logic                   irq_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef logic [3:0] oe_sel_t;

   typedef struct packed {
      logic [PINS-1:0]         dr;
      logic [PINS-1:0]         dm0;
      logic [PINS-1:0]         dm1;
      logic [PINS-1:0]         dm2;
      logic [PINS-1:0]         slw;
      logic [PINS-1:0]         bie;
      logic [PINS-1:0]         in_dis;
      logic [PINS-1:0]         reg_out;
      logic [7:0]              cfg;
      logic [PINS-1:0]         stat;
      logic [PINS-1:0]         mask;
      logic [2*PINS-1:0]       itype;
      logic [PINS*4-1:0]       oe_sel;
      logic [PINS-1:0]         sync1;
      logic [PINS-1:0]         sync2;
      logic [PINS-1:0]         prev;
      logic [7:0]              rdata;
   } state_t;

   state_t cur_ff;
   state_t nxt_ff;

   logic [PINS-1:0] edge_hit;
   logic [PINS-1:0] oe_sig;
   logic [PINS-1:0] res_mode;

   // ----------------------------------------------------------------
   // Per-pin logic
   // ----------------------------------------------------------------
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      logic [2:0] dm;
      logic [1:0] et;
      logic       rise;
      logic       fall;
      assign dm   = {cur_ff.dm2[i], cur_ff.dm1[i], cur_ff.dm0[i]};
      assign et   = cur_ff.itype[2*i +: 2];
      assign rise = cur_ff.sync2[i] & ~cur_ff.prev[i];
      assign fall = ~cur_ff.sync2[i] & cur_ff.prev[i];
      // Only edges, never levels
      assign edge_hit[i] =
         (et == io_port_pkg::EDGE_RISING && rise) ||
         (et == io_port_pkg::EDGE_FALLING && fall) ||
         (et == io_port_pkg::EDGE_BOTH && (rise || fall));
      assign oe_sig[i] = aux_oe_in[cur_ff.oe_sel[4*i +: 4]];
      assign res_mode[i] = (dm == io_port_pkg::DM_RES_UP) ||
                           (dm == io_port_pkg::DM_RES_DOWN) ||
                           (dm == io_port_pkg::DM_RES_UPDOWN);
      always_comb begin
         pad_mode_out[3*i +: 3] = dm;
         // Bidirectional: input while enable low
         if (cur_ff.bie[i] && !oe_sig[i]) begin
            pad_mode_out[3*i +: 3] = io_port_pkg::DM_HIZ_DIGITAL;
         end
         // Pull modes unavailable with regulated output
         if (cur_ff.reg_out[i] && res_mode[i]) begin
            pad_mode_out[3*i +: 3] = io_port_pkg::DM_HIZ_DIGITAL;
         end
      end
      assign pad_oe_out[i] =
         (pad_mode_out[3*i +: 3] != io_port_pkg::DM_HIZ_ANALOG) &&
         (pad_mode_out[3*i +: 3] != io_port_pkg::DM_HIZ_DIGITAL);
      // Slew masked off only in the three resistive pull modes
      assign pad_slow_out[i] = cur_ff.slw[i] & ~res_mode[i];
      assign pad_in_en_out[i] = ~cur_ff.in_dis[i] &&
                                (dm != io_port_pkg::DM_HIZ_ANALOG);
   end

   assign pad_out     = (bypass_in & sys_out_in) | (~bypass_in & cur_ff.dr);
   assign pad_reg_out = cur_ff.reg_out;
   assign sys_in_out  = cur_ff.sync2 & pad_in_en_out;
   assign lvttl_out   = cur_ff.cfg[io_port_pkg::CFG_LVTTL_BIT];
   assign hyst_en_out = cur_ff.cfg[io_port_pkg::CFG_HYST_BIT];
   assign ref_sel_out = cur_ff.cfg[io_port_pkg::CFG_THR_LSB +: 2];
   assign comp_en_out = cur_ff.cfg[io_port_pkg::CFG_COMP_BIT];
   assign irq_out     = |(cur_ff.stat & cur_ff.mask);
   assign rdata_out   = cur_ff.rdata;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [2:0] pidx;
      logic [PINS-1:0] clr;
      nxt_ff = cur_ff;
      pidx   = addr_in[2:0];
      clr    = '0;
      // Two-stage input synchroniser; no sleep gating
      nxt_ff.sync1 = pad_in;
      nxt_ff.sync2 = cur_ff.sync1;
      nxt_ff.prev  = cur_ff.sync2;
      nxt_ff.rdata = 8'h00;
      if (rd_in) begin
         if (addr_in == io_port_pkg::ADR_DATA_OUT) begin
            nxt_ff.rdata = cur_ff.dr;
         end else if (addr_in == io_port_pkg::ADR_PIN_STATE) begin
            nxt_ff.rdata = cur_ff.sync2;
         end else if (addr_in == io_port_pkg::ADR_DM0) begin
            nxt_ff.rdata = cur_ff.dm0;
         end else if (addr_in == io_port_pkg::ADR_DM1) begin
            nxt_ff.rdata = cur_ff.dm1;
         end else if (addr_in == io_port_pkg::ADR_DM2) begin
            nxt_ff.rdata = cur_ff.dm2;
         end else if (addr_in == io_port_pkg::ADR_SLEW) begin
            nxt_ff.rdata = cur_ff.slw;
         end else if (addr_in == io_port_pkg::ADR_BIDIR_EN) begin
            nxt_ff.rdata = cur_ff.bie;
         end else if (addr_in == io_port_pkg::ADR_IN_DIS) begin
            nxt_ff.rdata = cur_ff.in_dis;
         end else if (addr_in == io_port_pkg::ADR_REG_OUT) begin
            nxt_ff.rdata = cur_ff.reg_out;
         end else if (addr_in == io_port_pkg::ADR_PORT_CFG) begin
            nxt_ff.rdata = cur_ff.cfg;
         end else if (addr_in == io_port_pkg::ADR_INT_STAT) begin
            nxt_ff.rdata = cur_ff.stat;
            clr = cur_ff.stat;
         end else if (addr_in == io_port_pkg::ADR_INT_MASK) begin
            nxt_ff.rdata = cur_ff.mask;
         end else if (addr_in == io_port_pkg::ADR_INT_TYPE_L) begin
            nxt_ff.rdata = cur_ff.itype[7:0];
         end else if (addr_in == io_port_pkg::ADR_INT_TYPE_H) begin
            nxt_ff.rdata = cur_ff.itype[15:8];
         end else if (addr_in[5:4] == 2'h1 && addr_in[3] == 1'b0) begin
            nxt_ff.rdata = {4'h0, cur_ff.oe_sel[4*pidx +: 4]};
         end else if (addr_in[5:3] == 3'h4) begin
            // Pin form assembles the same bits as the port form
            nxt_ff.rdata = {cur_ff.reg_out[pidx], cur_ff.in_dis[pidx],
                            cur_ff.bie[pidx], cur_ff.slw[pidx],
                            cur_ff.dm2[pidx], cur_ff.dm1[pidx],
                            cur_ff.dm0[pidx], cur_ff.dr[pidx]};
         end
      end
      if (wr_in) begin
         if (addr_in == io_port_pkg::ADR_DATA_OUT) begin
            nxt_ff.dr = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_DM0) begin
            nxt_ff.dm0 = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_DM1) begin
            nxt_ff.dm1 = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_DM2) begin
            nxt_ff.dm2 = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_SLEW) begin
            nxt_ff.slw = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_BIDIR_EN) begin
            nxt_ff.bie = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_IN_DIS) begin
            nxt_ff.in_dis = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_REG_OUT) begin
            nxt_ff.reg_out = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_PORT_CFG) begin
            nxt_ff.cfg = {3'h0, wdata_in[4:0]};
         end else if (addr_in == io_port_pkg::ADR_INT_STAT) begin
            clr = clr | wdata_in;
         end else if (addr_in == io_port_pkg::ADR_INT_MASK) begin
            nxt_ff.mask = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_INT_TYPE_L) begin
            nxt_ff.itype[7:0] = wdata_in;
         end else if (addr_in == io_port_pkg::ADR_INT_TYPE_H) begin
            nxt_ff.itype[15:8] = wdata_in;
         end else if (addr_in[5:4] == 2'h1 && addr_in[3] == 1'b0) begin
            nxt_ff.oe_sel[4*pidx +: 4] = wdata_in[3:0];
         end else if (addr_in[5:3] == 3'h4) begin
            nxt_ff.dr[pidx]      = wdata_in[io_port_pkg::PIN_DR_BIT];
            nxt_ff.dm0[pidx]     = wdata_in[io_port_pkg::PIN_DM_LSB];
            nxt_ff.dm1[pidx]     = wdata_in[io_port_pkg::PIN_DM_LSB + 1];
            nxt_ff.dm2[pidx]     = wdata_in[io_port_pkg::PIN_DM_LSB + 2];
            nxt_ff.slw[pidx]     = wdata_in[io_port_pkg::PIN_SLW_BIT];
            nxt_ff.bie[pidx]     = wdata_in[io_port_pkg::PIN_BIE_BIT];
            nxt_ff.in_dis[pidx]  = wdata_in[io_port_pkg::PIN_DIS_BIT];
            nxt_ff.reg_out[pidx] = wdata_in[io_port_pkg::PIN_REG_BIT];
         end
      end
      // New edges win over a clear in the same cycle
      nxt_ff.stat = (cur_ff.stat & ~clr) | edge_hit;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cur_ff        <= '0;
         cur_ff.in_dis <= io_port_pkg::RST_IN_DIS;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

endmodule : io_port_ctrl

// [inc/io_port_pkg.sv]
package io_port_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int unsigned PIN_COUNT  = 8;
   localparam int unsigned OE_COUNT   = 16;
   localparam int unsigned OE_SEL_W   = 4;
   localparam int unsigned ADDR_W     = 6;
   localparam int unsigned DATA_W     = 8;

   // ----------------------------------------------------------------
   // Drive modes
   // ----------------------------------------------------------------
   localparam logic [2:0] DM_HIZ_ANALOG  = 3'h0;
   localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
   localparam logic [2:0] DM_RES_UP      = 3'h2;
   localparam logic [2:0] DM_RES_DOWN    = 3'h3;
   localparam logic [2:0] DM_OD_LOW      = 3'h4;
   localparam logic [2:0] DM_OD_HIGH     = 3'h5;
   localparam logic [2:0] DM_STRONG      = 3'h6;
   localparam logic [2:0] DM_RES_UPDOWN  = 3'h7;

   // ----------------------------------------------------------------
   // Edge modes
   // ----------------------------------------------------------------
   localparam logic [1:0] EDGE_NONE    = 2'h0;
   localparam logic [1:0] EDGE_RISING  = 2'h1;
   localparam logic [1:0] EDGE_FALLING = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;

   // ----------------------------------------------------------------
   // Register offsets (port form, then OE select and pin form bases)
   // ----------------------------------------------------------------
   localparam logic [5:0] ADR_DATA_OUT   = 6'h00;
   localparam logic [5:0] ADR_PIN_STATE  = 6'h01;
   localparam logic [5:0] ADR_DM0        = 6'h02;
   localparam logic [5:0] ADR_DM1        = 6'h03;
   localparam logic [5:0] ADR_DM2        = 6'h04;
   localparam logic [5:0] ADR_SLEW       = 6'h05;
   localparam logic [5:0] ADR_BIDIR_EN   = 6'h06;
   localparam logic [5:0] ADR_IN_DIS     = 6'h07;
   localparam logic [5:0] ADR_REG_OUT    = 6'h08;
   localparam logic [5:0] ADR_PORT_CFG   = 6'h09;
   localparam logic [5:0] ADR_INT_STAT   = 6'h0a;
   localparam logic [5:0] ADR_INT_MASK   = 6'h0b;
   localparam logic [5:0] ADR_INT_TYPE_L = 6'h0c;
   localparam logic [5:0] ADR_INT_TYPE_H = 6'h0d;
   localparam logic [5:0] ADR_OE_SEL_0   = 6'h10;
   localparam logic [5:0] ADR_PIN_0      = 6'h20;

   // Port configuration byte fields
   localparam int unsigned CFG_LVTTL_BIT = 0;
   localparam int unsigned CFG_HYST_BIT  = 1;
   localparam int unsigned CFG_THR_LSB   = 2;
   localparam int unsigned CFG_COMP_BIT  = 4;

   // Per-pin register fields
   localparam int unsigned PIN_DR_BIT   = 0;
   localparam int unsigned PIN_PS_BIT   = 1;
   localparam int unsigned PIN_DM_LSB   = 1;
   localparam int unsigned PIN_SLW_BIT  = 4;
   localparam int unsigned PIN_BIE_BIT  = 5;
   localparam int unsigned PIN_DIS_BIT  = 6;
   localparam int unsigned PIN_REG_BIT  = 7;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [7:0] RST_IN_DIS = 8'hff;

   // Input reference selects
   localparam logic [1:0] THR_HALF_VDDIO = 2'h0;
   localparam logic [1:0] THR_04_VDDIO   = 2'h1;
   localparam logic [1:0] THR_HALF_VREF  = 2'h2;
   localparam logic [1:0] THR_VREF       = 2'h3;

endpackage : io_port_pkg

// [testbench/io_port_sva.sv]
`timescale 1ns/1ps
module io_port_sva #(
   parameter int unsigned PINS = 8,
   parameter int unsigned OES  = 16
) (
   // Clock, reset and register port
   input wire logic              clk_in,
   input wire logic              rst_b_in,
   input wire logic [5:0]        addr_in,
   input wire logic [7:0]        wdata_in,
   input wire logic              wr_in,
   input wire logic              rd_in,
   input wire logic [7:0]        rdata_out,
   // Logic side
   input wire logic [OES-1:0]    aux_oe_in,
   input wire logic [PINS-1:0]   sys_out_in,
   input wire logic [PINS-1:0]   bypass_in,
   input wire logic [PINS-1:0]   sys_in_out,
   // Pads and port controls
   input wire logic [PINS-1:0]   pad_in,
   input wire logic [PINS-1:0]   pad_out,
   input wire logic [PINS-1:0]   pad_oe_out,
   input wire logic [3*PINS-1:0] pad_mode_out,
   input wire logic [PINS-1:0]   pad_slow_out,
   input wire logic [PINS-1:0]   pad_in_en_out,
   input wire logic [PINS-1:0]   pad_reg_out,
   input wire logic              lvttl_out,
   input wire logic              hyst_en_out,
   input wire logic [1:0]        ref_sel_out,
   input wire logic              comp_en_out,
   input wire logic              irq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   a_reset_quiet: assert property ($rose(rst_b_in) |-> pad_oe_out == '0 &&
      pad_in_en_out == '0 && pad_mode_out == '0 && !irq_out)
      else $error("pins not idle after reset");
   a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside read slot");
   a_unmapped_read: assert property (rd_in && addr_in == 6'h3f |=>
      rdata_out == 8'h00) else $error("unmapped read not zero");
   // Quiet pins for five cycles: nothing new may reach status after read
   a_irq_read_clear: assert property ($stable(pad_in)[*5] ##0
      (rd_in && addr_in == io_port_pkg::ADR_INT_STAT) |-> ##3 !irq_out)
      else $error("request kept after status read");
   a_input_gated: assert property ((sys_in_out & ~pad_in_en_out) == '0)
      else $error("disabled input reaches logic");
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      wire logic [2:0] mode = pad_mode_out[3*i+:3];
      a_oe_mode: assert property (pad_oe_out[i] == (mode > 3'h1))
         else $error("output enable disagrees with mode");
      a_slew_res: assert property (mode inside {3'h2, 3'h3, 3'h7} |->
         !pad_slow_out[i]) else $error("slow slew in resistive mode");
      a_reg_nopull: assert property (pad_reg_out[i] |->
         !(mode inside {3'h2, 3'h3, 3'h7})) else $error("pull with regulation");
      a_analog_noin: assert property (mode == 3'h0 |-> !pad_in_en_out[i])
         else $error("input buffer on in analog mode");
   end

   cover property ($rose(irq_out));
   cover property ($rose(pad_oe_out[1]));
   cover property (rd_in && addr_in == io_port_pkg::ADR_INT_STAT
      ##1 rdata_out != 8'h00);
endmodule : io_port_sva

bind io_port_ctrl io_port_sva #(.PINS(PINS), .OES(OES)) i_io_port_sva (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .aux_oe_in(aux_oe_in), .sys_out_in(sys_out_in), .bypass_in(bypass_in),
   .sys_in_out(sys_in_out), .pad_in(pad_in), .pad_out(pad_out),
   .pad_oe_out(pad_oe_out), .pad_mode_out(pad_mode_out),
   .pad_slow_out(pad_slow_out), .pad_in_en_out(pad_in_en_out),
   .pad_reg_out(pad_reg_out), .lvttl_out(lvttl_out),
   .hyst_en_out(hyst_en_out), .ref_sel_out(ref_sel_out),
   .comp_en_out(comp_en_out), .irq_out(irq_out));

// [testbench/pin_far_side.sv]
`timescale 1ns/1ps
module pin_far_side (
   // Clock and bench commands
   input  wire logic        clk_in,
   input  wire logic [7:0]  ext_lvl_in,
   input  wire logic [15:0] aux_cmd_in,
   // Port pads
   input  wire logic [7:0]  pad_out_in,
   input  wire logic [7:0]  pad_oe_in,
   output logic      [7:0]  pad_lvl_out,
   output logic      [15:0] aux_oe_out
);
   logic [7:0] ext_ff = 8'h00;
   // Outside world moves only just after an edge, like on-chip logic
   always @(posedge clk_in) begin
      ext_ff <= ext_lvl_in;
      aux_oe_out <= aux_cmd_in;
   end
   // A driven pad shows the port's own level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_lvl_out[i] = pad_oe_in[i] ? pad_out_in[i] : ext_ff[i];
      end
   end
endmodule : pin_far_side

// [testbench/tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
   err_count++; $display("wrong value %0t %h %h", $time, (a), (e)); end end
module tb;
   logic        clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic [5:0]  addr_in = 6'h00;
   logic [7:0]  wdata_in = 8'h00, sys_out_in = 8'h00, bypass_in = 8'h00;
   logic [7:0]  ext = 8'h00, d, v;
   logic [15:0] aux_cmd = 16'h0000, aux_oe_in;
   logic [7:0]  pad_in, rdata_out, sys_in_out, pad_out, pad_oe_out;
   logic [7:0]  pad_slow_out, pad_in_en_out, pad_reg_out;
   logic [23:0] pad_mode_out;
   logic [1:0]  ref_sel_out;
   logic        lvttl_out, hyst_en_out, comp_en_out, irq_out;
   int          err_count = 0, comparisons = 0, seed = 20, k;

   always #2.5 clk_in = ~clk_in;

   io_port_ctrl i_io_port_ctrl (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .aux_oe_in(aux_oe_in), .sys_out_in(sys_out_in),
      .bypass_in(bypass_in), .sys_in_out(sys_in_out), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_out(pad_oe_out),
      .pad_mode_out(pad_mode_out), .pad_slow_out(pad_slow_out),
      .pad_in_en_out(pad_in_en_out), .pad_reg_out(pad_reg_out),
      .lvttl_out(lvttl_out), .hyst_en_out(hyst_en_out),
      .ref_sel_out(ref_sel_out), .comp_en_out(comp_en_out),
      .irq_out(irq_out));
   pin_far_side i_pin_far_side (.clk_in(clk_in), .ext_lvl_in(ext),
      .aux_cmd_in(aux_cmd), .pad_out_in(pad_out), .pad_oe_in(pad_oe_out),
      .pad_lvl_out(pad_in), .aux_oe_out(aux_oe_in));

   // ----------------------------------------------------------------
   // Bus cycles and expectations
   // ----------------------------------------------------------------
   task automatic wr(input logic [5:0] a, input logic [7:0] x);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= x;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] q);
      @(posedge clk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 q = rdata_out;
   endtask : rd
   function automatic logic hit(input logic [1:0] t, input logic rise);
      return t == io_port_pkg::EDGE_BOTH ||
         t == (rise ? io_port_pkg::EDGE_RISING : io_port_pkg::EDGE_FALLING);
   endfunction : hit
   function automatic logic [2:0] bidir_mode(input logic en);
      return en ? io_port_pkg::DM_STRONG : io_port_pkg::DM_HIZ_DIGITAL;
   endfunction : bidir_mode
   task stop_test;
      if (err_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      for (int a = 0; a < 14; a++) if (a != 1) begin
         rd(a[5:0], d);
         `CHK(d, a == 7 ? io_port_pkg::RST_IN_DIS : io_port_pkg::RST_BYTE)
      end
      for (int m = 0; m < 8; m++) begin
         wr(io_port_pkg::ADR_PIN_0, {4'h1, m[2:0], 1'b0});
         rd(io_port_pkg::ADR_DM0, d);
         `CHK(d[0], m[0])
         `CHK(pad_mode_out[2:0], m[2:0])
         `CHK(pad_in_en_out[0], m != 0)
         if (m > 1) `CHK(pad_slow_out[0], m > 3 && m < 7)
      end
      for (int n = 0; n < 6; n++) begin
         k = $random(seed) & 15;
         wr(io_port_pkg::ADR_OE_SEL_0 + 6'h01, {4'h0, k[3:0]});
         wr(io_port_pkg::ADR_OE_SEL_0 + 6'h02, {4'h0, k[3:0]});
         wr(io_port_pkg::ADR_PIN_0 + 6'h01, 8'h2d);
         wr(io_port_pkg::ADR_PIN_0 + 6'h02, 8'h2c);
         @(posedge clk_in);
         aux_cmd <= $random(seed);
         sys_out_in <= $random(seed);
         bypass_in <= $random(seed);
         repeat (2) @(posedge clk_in);
         #1 `CHK(pad_mode_out[5:3], bidir_mode(aux_cmd[k]))
         `CHK(pad_mode_out[8:6], bidir_mode(aux_cmd[k]))
         `CHK(pad_oe_out[2:1], {2{aux_cmd[k]}})
         // Pin 1 holds a one in its data bit, pin 2 a zero
         d = {6'h00, bypass_in[2] ? sys_out_in[2] : 1'b0,
              bypass_in[1] ? sys_out_in[1] : 1'b1};
         `CHK(pad_out[2:1], d[1:0])
         v = $random(seed);
         wr(io_port_pkg::ADR_PORT_CFG, v);
         rd(io_port_pkg::ADR_PORT_CFG, d);
         `CHK(d, v & 8'h1f)
         `CHK({comp_en_out, ref_sel_out, hyst_en_out, lvttl_out}, v[4:0])
      end
      wr(io_port_pkg::ADR_DM0, 8'hff);
      wr(io_port_pkg::ADR_DM1, 8'h00);
      wr(io_port_pkg::ADR_DM2, 8'h00);
      wr(io_port_pkg::ADR_BIDIR_EN, 8'h00);
      for (int n = 0; n < 4; n++) begin
         v = $random(seed);
         wr(io_port_pkg::ADR_IN_DIS, v);
         `CHK(pad_in_en_out, ~v)
         `CHK(pad_mode_out, {8{io_port_pkg::DM_HIZ_DIGITAL}})
         @(posedge clk_in);
         ext <= $random(seed);
         repeat (4) @(posedge clk_in);
         #1 `CHK(sys_in_out, ext & ~v)
         rd(io_port_pkg::ADR_PIN_STATE, d);
         `CHK(d, ext)
      end
      wr(io_port_pkg::ADR_IN_DIS, 8'h00);
      @(posedge clk_in);
      ext <= 8'h00;
      repeat (8) @(posedge clk_in);
      rd(io_port_pkg::ADR_INT_STAT, d);
      wr(io_port_pkg::ADR_INT_MASK, 8'h08);
      // Only pin 3 has an edge type, so other bits stay clear
      for (int t = 0; t < 4; t++) begin
         wr(io_port_pkg::ADR_INT_TYPE_L, {t[1:0], 6'h00});
         for (int r = 1; r >= 0; r--) begin
            @(posedge clk_in);
            ext <= {4'h0, r[0], 3'h0};
            repeat (8) @(posedge clk_in);
            #1 `CHK(irq_out, hit(t[1:0], r[0]))
            rd(io_port_pkg::ADR_INT_STAT, d);
            `CHK(d, {4'h0, hit(t[1:0], r[0]), 3'h0})
            rd(io_port_pkg::ADR_INT_STAT, d);
            `CHK(d, 8'h00)
            repeat (3) @(posedge clk_in);
            #1 `CHK(irq_out, 1'b0)
         end
      end
      // Write-one clear, other bits untouched; mask gates the request
      @(posedge clk_in);
      ext <= 8'h08;
      repeat (8) @(posedge clk_in);
      wr(io_port_pkg::ADR_INT_STAT, 8'hf7);
      `CHK(irq_out, 1'b1)
      wr(io_port_pkg::ADR_INT_MASK, 8'h00);
      `CHK(irq_out, 1'b0)
      wr(io_port_pkg::ADR_INT_STAT, 8'h08);
      rd(io_port_pkg::ADR_INT_STAT, d);
      `CHK(d, 8'h00)
      wr(io_port_pkg::ADR_PIN_0 + 6'h04, 8'h84);
      `CHK(pad_reg_out[4], 1'b1)
      `CHK(pad_mode_out[14:12], io_port_pkg::DM_HIZ_DIGITAL)
      wr(6'h3f, 8'hff);
      rd(6'h3f, d);
      `CHK(d, 8'h00)
      stop_test;
   end

   initial begin
      #100000;
      err_count++;
      stop_test;
   end
endmodule : tb
